// *** core/sula_alu.sv ***
// Top of the unsigned lane ALU: operation decode and registered result
`timescale 1ns/1ps
module sula_alu (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_valid,
  input  wire logic [3:0]  i_op,
  input  wire logic [31:0] i_first,
  input  wire logic [31:0] i_second,
  input  wire logic [31:0] i_accum,
  input  wire logic [3:0]  i_lane_compare_flags,
  output logic             o_valid,
  output logic      [31:0] o_result
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Halve a 17-bit widened halfword sum or difference
  function automatic logic [15:0] halve16(input logic [15:0] a, input logic [15:0] b,
                                          input logic sub);
    logic [16:0] t;
    t = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    return t[16:1];
  endfunction

  // Absolute difference of two bytes
  function automatic logic [7:0] absdiff8(input logic [7:0] a, input logic [7:0] b);
    return (a >= b) ? (a - b) : (b - a);
  endfunction

  // ---------------------------------------------------------------
  // Lane datapath
  // ---------------------------------------------------------------
  sula_pkg::sula_op_t op;
  logic        is_sub;
  logic        is_byte;
  logic [31:0] lane_halved;
  logic [31:0] lane_plain;
  logic [31:0] sad_sum;
  logic [31:0] sel_word;
  logic [31:0] exch_word;
  logic [31:0] next_result;
  logic        next_valid;

  assign op      = sula_pkg::sula_op_t'(i_op);
  // Subtract and byte-lane mode decode
  assign is_sub  = (op == sula_pkg::SULA_OP_HSUB_TWO) || (op == sula_pkg::SULA_OP_HSUB_FOUR)
                || (op == sula_pkg::SULA_OP_SUB_TWO)  || (op == sula_pkg::SULA_OP_SUB_FOUR);
  assign is_byte = (op == sula_pkg::SULA_OP_HADD_FOUR) || (op == sula_pkg::SULA_OP_HSUB_FOUR)
                || (op == sula_pkg::SULA_OP_SUB_FOUR);

  sula_lane_arith i_sula_lane_arith (
    .i_first     (i_first),
    .i_second    (i_second),
    .i_sub       (is_sub),
    .i_byte_mode (is_byte),
    .o_halved    (lane_halved),
    .o_plain     (lane_plain)
  );

  // Exchange forms, sum of absolute differences and byte select
  always_comb begin
    if (op == sula_pkg::SULA_OP_HADD_SUB_EXCH) begin
      exch_word[31:16] = halve16(i_first[31:16], i_second[15:0], 1'b0);
      exch_word[15:0]  = halve16(i_first[15:0], i_second[31:16], 1'b1);
    end else begin
      exch_word[31:16] = halve16(i_first[31:16], i_second[15:0], 1'b1);
      exch_word[15:0]  = halve16(i_first[15:0], i_second[31:16], 1'b0);
    end
    sad_sum = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      sad_sum = sad_sum + {24'h00_0000, absdiff8(i_first[8*b +: 8], i_second[8*b +: 8])};
      sel_word[8*b +: 8] = i_lane_compare_flags[b] ? i_first[8*b +: 8]
                                                   : i_second[8*b +: 8];
    end
  end

  // Result selection; no flag output exists, so condition codes stay put
  always_comb begin
    next_valid = i_valid;
    case (op)
      sula_pkg::SULA_OP_HADD_TWO,
      sula_pkg::SULA_OP_HADD_FOUR,
      sula_pkg::SULA_OP_HSUB_TWO,
      sula_pkg::SULA_OP_HSUB_FOUR:     next_result = lane_halved;
      sula_pkg::SULA_OP_HADD_SUB_EXCH,
      sula_pkg::SULA_OP_HSUB_ADD_EXCH: next_result = exch_word;
      sula_pkg::SULA_OP_SELECT:        next_result = sel_word;
      sula_pkg::SULA_OP_SAD:           next_result = sad_sum;
      sula_pkg::SULA_OP_SAD_ACC:       next_result = sad_sum + i_accum;
      sula_pkg::SULA_OP_SUB_TWO,
      sula_pkg::SULA_OP_SUB_FOUR:      next_result = lane_plain;
      default: begin
        next_result = o_result;
        next_valid  = 1'b0;
      end
    endcase
    if (!i_valid) begin
      next_result = o_result;
    end
  end

  // Result register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_result <= sula_pkg::SULA_RESULT_RST;
      o_valid  <= 1'b0;
    end else begin
      o_result <= next_result;
      o_valid  <= next_valid;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_HADD_TWO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_TWO |=> o_valid &&
    o_result[15:0] == 16'(({1'b0, $past(i_first[15:0])} + {1'b0, $past(i_second[15:0])}) >> 1))
    else $error("two-lane halving add low lane wrong");
  AST_HADD_FOUR: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_FOUR |=>
    o_result[31:24] == 8'(({1'b0, $past(i_first[31:24])} + {1'b0, $past(i_second[31:24])}) >> 1))
    else $error("four-lane halving add top byte wrong");
  AST_ASX_HI: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_SUB_EXCH |=>
    o_result[31:16] == 16'(({1'b0, $past(i_first[31:16])} + {1'b0, $past(i_second[15:0])}) >> 1))
    else $error("add-sub exchange high half wrong");
  AST_ASX_LO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_SUB_EXCH |=>
    o_result[15:0] == 16'(({1'b0, $past(i_first[15:0])} - {1'b0, $past(i_second[31:16])}) >> 1))
    else $error("add-sub exchange low half wrong");
  AST_SAX: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HSUB_ADD_EXCH |=>
    o_result[31:16] == 16'(({1'b0, $past(i_first[31:16])} - {1'b0, $past(i_second[15:0])}) >> 1)
    && o_result[15:0] == 16'(({1'b0, $past(i_first[15:0])} + {1'b0, $past(i_second[31:16])}) >> 1))
    else $error("sub-add exchange wrong");
  AST_HSUB_TWO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HSUB_TWO |=>
    o_result[31:16] == 16'(({1'b0, $past(i_first[31:16])} - {1'b0, $past(i_second[31:16])}) >> 1))
    else $error("two-lane halving subtract wrong");
  AST_SELECT: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SELECT && i_lane_compare_flags[0] |=>
    o_result[7:0] == $past(i_first[7:0]))
    else $error("set flag did not pick first operand byte");
  AST_SAD_ACC: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SAD_ACC && i_first == i_second |=>
    o_result == $past(i_accum))
    else $error("accumulate with zero differences wrong");
  AST_SUB_FOUR: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SUB_FOUR |=>
    o_result[7:0] == 8'($past(i_first[7:0]) - $past(i_second[7:0])))
    else $error("four-lane subtract wrong");
  AST_IDLE_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_valid |=> !o_valid && $stable(o_result))
    else $error("result changed without a request");

  // ---------------------------------------------------------------
  // Further lane checks
  // ---------------------------------------------------------------
  // Upper halfword of the two-lane halving add
  AST_HADD_TWO_HI: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_TWO |=>
    o_result[31:16] == 16'(({1'b0, $past(i_first[31:16])} + {1'b0, $past(i_second[31:16])}) >> 1))
    else $error("two-lane halving add high lane wrong");

  // Lowest byte of the four-lane halving add
  AST_HADD_FOUR_LO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_FOUR |=>
    o_result[7:0] == 8'(({1'b0, $past(i_first[7:0])} + {1'b0, $past(i_second[7:0])}) >> 1))
    else $error("four-lane halving add low byte wrong");

  // Carry of the top byte sum lands in bit 31
  AST_CARRY_TOP: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HADD_FOUR |=>
    o_result[31] == (({1'b0, $past(i_first[31:24])} + {1'b0, $past(i_second[31:24])}) >= 9'h100))
    else $error("halving add lost its carry bit");

  // Borrow of the low byte difference lands in bit 7
  AST_BORROW_LO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HSUB_FOUR |=>
    o_result[7] == ($past(i_first[7:0]) < $past(i_second[7:0])))
    else $error("halving subtract lost its borrow bit");

  // Lower halfword of the two-lane halving subtract
  AST_HSUB_TWO_LO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HSUB_TWO |=>
    o_result[15:0] == 16'(({1'b0, $past(i_first[15:0])} - {1'b0, $past(i_second[15:0])}) >> 1))
    else $error("two-lane halving subtract low lane wrong");

  // Second byte of the four-lane halving subtract
  AST_HSUB_FOUR: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_HSUB_FOUR |=>
    o_result[15:8] == 8'(({1'b0, $past(i_first[15:8])} - {1'b0, $past(i_second[15:8])}) >> 1))
    else $error("four-lane halving subtract wrong");

  // Clear flag takes the second operand byte
  AST_SELECT_CLR: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SELECT && !i_lane_compare_flags[3] |=>
    o_result[31:24] == $past(i_second[31:24]))
    else $error("clear flag did not pick second operand byte");

  // All flags set pass the first operand whole
  AST_SELECT_ALL: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SELECT && i_lane_compare_flags == 4'hF |=>
    o_result == $past(i_first))
    else $error("all flags set did not pass first operand");

  // Zero first operand makes each difference the second operand byte
  AST_SAD: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SAD && i_first == 32'h0000_0000 |=>
    o_result == 32'($past(i_second[31:24])) + 32'($past(i_second[23:16]))
              + 32'($past(i_second[15:8])) + 32'($past(i_second[7:0])))
    else $error("sum of absolute differences wrong");

  // Upper halfword of the two-lane subtract
  AST_SUB_TWO: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && op == sula_pkg::SULA_OP_SUB_TWO |=>
    o_result[31:16] == 16'($past(i_first[31:16]) - $past(i_second[31:16])))
    else $error("two-lane subtract wrong");

  // Refused codes keep the result and raise no valid
  AST_REFUSE: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && (op == sula_pkg::SULA_OP_NONE || i_op > sula_pkg::SULA_OP_SUB_FOUR) |=>
    !o_valid && $stable(o_result))
    else $error("refused code changed the result");

  COV_HADD: cover property (@(posedge i_clock) i_valid && op == sula_pkg::SULA_OP_HADD_TWO);
  COV_SEL:  cover property (@(posedge i_clock) i_valid && op == sula_pkg::SULA_OP_SELECT);
  COV_SADA: cover property (@(posedge i_clock) i_valid && op == sula_pkg::SULA_OP_SAD_ACC);
  COV_EXCH: cover property (@(posedge i_clock) i_valid && op == sula_pkg::SULA_OP_HSUB_ADD_EXCH);
  COV_NOOP: cover property (@(posedge i_clock) i_valid && op == sula_pkg::SULA_OP_NONE);
endmodule

// *** core/sula_pkg.sv ***
// Package of operation codes and lane constants for the unsigned lane ALU
package sula_pkg;

  // ---------------------------------------------------------------
  // Operation select codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SULA_OP_NONE          = 4'h0,
    SULA_OP_HADD_TWO      = 4'h1,
    SULA_OP_HADD_FOUR     = 4'h2,
    SULA_OP_HADD_SUB_EXCH = 4'h3,
    SULA_OP_HSUB_ADD_EXCH = 4'h4,
    SULA_OP_HSUB_TWO      = 4'h5,
    SULA_OP_HSUB_FOUR     = 4'h6,
    SULA_OP_SELECT        = 4'h7,
    SULA_OP_SAD           = 4'h8,
    SULA_OP_SAD_ACC       = 4'h9,
    SULA_OP_SUB_TWO       = 4'hA,
    SULA_OP_SUB_FOUR      = 4'hB
  } sula_op_t;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          SULA_WORD_W    = 32;
  localparam int          SULA_HALF_W    = 16;
  localparam int          SULA_BYTE_W    = 8;
  localparam int          SULA_FLAG_W    = 4;
  localparam int          SULA_LATENCY   = 1;
  localparam logic [31:0] SULA_RESULT_RST = 32'h0000_0000;

endpackage

// *** core/sula_lane_arith.sv ***
// Lane arithmetic: halving add/sub on halfwords and bytes, with carry bit
`timescale 1ns/1ps
module sula_lane_arith (
  input  wire logic [31:0] i_first,
  input  wire logic [31:0] i_second,
  input  wire logic        i_sub,
  input  wire logic        i_byte_mode,
  output logic      [31:0] o_halved,
  output logic      [31:0] o_plain
);
  // ---------------------------------------------------------------
  // Per-lane 9 and 17 bit arithmetic
  // ---------------------------------------------------------------
  logic [16:0] h_res [2];
  logic [8:0]  b_res [4];

  // Widened lane sums/differences, top bit keeps carry or borrow
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      h_res[h] = i_sub ? ({1'b0, i_first[16*h +: 16]} - {1'b0, i_second[16*h +: 16]})
                       : ({1'b0, i_first[16*h +: 16]} + {1'b0, i_second[16*h +: 16]});
    end
    for (int b = 0; b < 4; b++) begin
      b_res[b] = i_sub ? ({1'b0, i_first[8*b +: 8]} - {1'b0, i_second[8*b +: 8]})
                       : ({1'b0, i_first[8*b +: 8]} + {1'b0, i_second[8*b +: 8]});
    end
  end

  // Shift right one bit per lane, or keep low bits for plain subtract
  always_comb begin
    if (i_byte_mode) begin
      for (int b = 0; b < 4; b++) begin
        o_halved[8*b +: 8] = b_res[b][8:1];
        o_plain[8*b +: 8]  = b_res[b][7:0];
      end
    end else begin
      for (int h = 0; h < 2; h++) begin
        o_halved[16*h +: 16] = h_res[h][16:1];
        o_plain[16*h +: 16]  = h_res[h][15:0];
      end
    end
  end
endmodule

// *** tb/sula_decoder_model.sv ***
// Issuer model that feeds operands to the lane ALU
`timescale 1ns/1ps
module sula_decoder_model (
  input  wire logic        i_clock,
  output logic             o_valid,
  output logic      [3:0]  o_op,
  output logic      [31:0] o_first,
  output logic      [31:0] o_second,
  output logic      [31:0] o_accum,
  output logic      [3:0]  o_flags
);
  // Idle request lines at time zero
  initial begin
    o_valid = 1'b0;
    {o_op, o_first, o_second, o_accum, o_flags} = '0;
  end
  // One request just after an edge, held until the next edge takes it
  task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] c, input logic [3:0] f);
    @(posedge i_clock);
    #1;
    o_valid = 1'b1;
    o_op = op;
    o_first = a;
    o_second = b;
    o_accum = c;
    o_flags = f;
  endtask
  // Released lines show inverted stale values, not the last request
  task automatic release_bus();
    @(posedge i_clock);
    #1;
    o_valid = 1'b0;
    {o_op, o_first, o_second, o_accum, o_flags} = ~{o_op, o_first, o_second, o_accum, o_flags};
  endtask
endmodule

// *** tb/tb_sula_alu.sv ***
// Self-checking bench for the unsigned lane ALU
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_sula_alu;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        req_valid;
  logic [3:0]  req_op;
  logic [31:0] req_first;
  logic [31:0] req_second;
  logic [31:0] req_accum;
  logic [3:0]  req_flags;
  logic        o_valid;
  logic [31:0] o_result;
  int          errors = 0;
  int          total_checks = 0;
  // 125 MHz core clock
  always #4 i_clock = ~i_clock;
  sula_decoder_model i_sula_decoder_model (.i_clock(i_clock), .o_valid(req_valid),
    .o_op(req_op), .o_first(req_first), .o_second(req_second), .o_accum(req_accum),
    .o_flags(req_flags));
  sula_alu i_sula_alu (.i_clock(i_clock), .i_rst(i_rst), .i_valid(req_valid), .i_op(req_op),
    .i_first(req_first), .i_second(req_second), .i_accum(req_accum),
    .i_lane_compare_flags(req_flags), .o_valid(o_valid), .o_result(o_result));
  // Halving lane helpers with one extra carry bit
  function automatic logic [15:0] hh(logic [15:0] x, logic [15:0] y, logic s);
    logic [16:0] t;
    t = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    return t[16:1];
  endfunction
  function automatic logic [7:0] hb(logic [7:0] x, logic [7:0] y, logic s);
    logic [8:0] t;
    t = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    return t[8:1];
  endfunction
  // Reference result for every operation code except SULA_OP_NONE
  function automatic logic [31:0] ref_op(logic [3:0] op, logic [31:0] a, logic [31:0] b,
                                         logic [31:0] c, logic [3:0] f);
    logic [31:0] r;
    logic [7:0]  x;
    logic [7:0]  y;
    r = (op == 4'h9) ? c : 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      x = a[8*i+:8];
      y = b[8*i+:8];
      case (op)
        4'h2: r[8*i+:8] = hb(x, y, 1'b0);
        4'h6: r[8*i+:8] = hb(x, y, 1'b1);
        4'h7: r[8*i+:8] = f[i] ? x : y;
        4'h8, 4'h9: r = r + 32'(x > y ? x - y : y - x);
        4'hB: r[8*i+:8] = x - y;
        default: ;
      endcase
    end
    case (op)
      4'h1: r = {hh(a[31:16], b[31:16], 1'b0), hh(a[15:0], b[15:0], 1'b0)};
      4'h3: r = {hh(a[31:16], b[15:0], 1'b0), hh(a[15:0], b[31:16], 1'b1)};
      4'h4: r = {hh(a[31:16], b[15:0], 1'b1), hh(a[15:0], b[31:16], 1'b0)};
      4'h5: r = {hh(a[31:16], b[31:16], 1'b1), hh(a[15:0], b[15:0], 1'b1)};
      4'hA: r = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
      default: ;
    endcase
    return r;
  endfunction
  // One request, answer judged one cycle later
  task automatic run_op(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
                        input logic [31:0] c, input logic [3:0] f);
    i_sula_decoder_model.issue(op, a, b, c, f);
    i_sula_decoder_model.release_bus();
    `CHK(o_valid, 1'b1)
    `CHK(o_result, ref_op(op, a, b, c, f))
  endtask
  task automatic t_halving();
    run_op(4'h1, 32'hFFFF_1235, 32'hFFFF_0002, 32'h0, 4'h0);
    run_op(4'h2, 32'hFF80_0103, 32'hFF7F_0001, 32'h0, 4'h0);
    run_op(4'h3, 32'hFFFF_0000, 32'h0001_0003, 32'h0, 4'h0);
    run_op(4'h4, 32'h0000_FFFF, 32'h0003_0005, 32'h0, 4'h0);
    run_op(4'h5, 32'h0000_8000, 32'h0001_0001, 32'h0, 4'h0);
    run_op(4'h6, 32'h0010_FF01, 32'h0111_0102, 32'h0, 4'h0);
  endtask
  task automatic t_select();
    for (int k = 0; k < 16; k++) begin
      run_op(4'h7, 32'h1122_3344, 32'hAABB_CCDD, 32'h0, 4'(k));
    end
  endtask
  task automatic t_sad_sub();
    run_op(4'h8, 32'h00FF_1080, 32'hFF00_2070, 32'h0, 4'h0);
    run_op(4'h9, 32'h00FF_1080, 32'hFF00_2070, 32'hFFFF_FF00, 4'h0);
    run_op(4'h8, 32'h0000_0000, 32'h0102_F0FF, 32'h0, 4'h0);
    run_op(4'h9, 32'h5A5A_5A5A, 32'h5A5A_5A5A, 32'h1234_5678, 4'h0);
    run_op(4'hA, 32'h0001_8000, 32'h0002_7FFF, 32'h0, 4'h0);
    run_op(4'hB, 32'h0010_FF00, 32'h0110_01FF, 32'h0, 4'h0);
  endtask
  // Invalid codes leave the result standing
  task automatic t_refuse();
    logic [31:0] held;
    held = o_result;
    for (int k = 11; k < 16; k++) begin
      i_sula_decoder_model.issue(k == 11 ? 4'h0 : 4'(k), 32'h5, 32'h3, 32'h1, 4'hF);
      i_sula_decoder_model.release_bus();
      `CHK(o_valid, 1'b0)
      `CHK(o_result, held)
    end
  endtask
  task automatic t_back2back();
    i_sula_decoder_model.issue(4'h1, 32'h1234_FFFF, 32'h4321_0001, 32'h0, 4'h0);
    i_sula_decoder_model.issue(4'hB, 32'h0102_0304, 32'h0403_0201, 32'h0, 4'h0);
    `CHK(o_result, ref_op(4'h1, 32'h1234_FFFF, 32'h4321_0001, 32'h0, 4'h0))
    i_sula_decoder_model.release_bus();
    `CHK(o_result, ref_op(4'hB, 32'h0102_0304, 32'h0403_0201, 32'h0, 4'h0))
    `CHK(o_valid, 1'b1)
  endtask
  // Mid-run reset clears a standing result and drops the pending request
  task automatic t_reset();
    i_sula_decoder_model.issue(4'h1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 4'h0);
    i_rst = 1'b1;
    i_sula_decoder_model.release_bus();
    `CHK(o_valid, 1'b0)
    `CHK(o_result, 32'h0000_0000)
    @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    `CHK(o_result, 32'h0000_0000)
    run_op(4'h4, 32'h8000_0001, 32'h0001_8000, 32'h0, 4'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence after five cycles of reset
  initial begin
    repeat (5) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    `CHK(o_valid, 1'b0)
    `CHK(o_result, 32'h0000_0000)
    t_halving();
    t_select();
    t_sad_sub();
    t_refuse();
    t_back2back();
    t_reset();
    print_verdict();
  end
  // Watchdog well beyond the roughly 80 cycles of traffic
  initial begin
    #20000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
